//--- logic/usf_buf2.sv
`timescale 1ns/1ps
module usf_buf2 #(
  parameter int W     = 8,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic         flush,
  // Fill side
  input  wire logic         inValid,
  output logic              inReady,
  input  wire logic [W-1:0] inData,
  // Drain side
  output logic              outValid,
  input  wire logic         outReady,
  output logic [W-1:0]      outData
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0]           wrPtr;
    logic [PW-1:0]           rdPtr;
    logic [CW-1:0]           count;
  } usf_buf_s;

  usf_buf_s cur;
  usf_buf_s next_cur;
  logic     push;
  logic     pop;

  // Pointer step with wrap
  function automatic logic [PW-1:0] stepPtr(input logic [PW-1:0] p);
    stepPtr = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction

  assign inReady  = (cur.count != FULL);
  assign outValid = (cur.count != '0);
  assign outData  = cur.mem[cur.rdPtr];
  assign push     = inValid & inReady;
  assign pop      = outValid & outReady;

  // Next state: flush empties the buffer
  always_comb
  begin
    next_cur = cur;
    if (push)
    begin
      next_cur.mem[cur.wrPtr] = inData;
      next_cur.wrPtr          = stepPtr(cur.wrPtr);
    end
    if (pop)
      next_cur.rdPtr = stepPtr(cur.rdPtr);
    next_cur.count = CW'(cur.count + CW'(push) - CW'(pop));
    if (flush)
    begin
      next_cur.wrPtr = '0;
      next_cur.rdPtr = '0;
      next_cur.count = '0;
    end
  end

  // State register
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      cur <= '0;
    else
      cur <= next_cur;
  end

  no_overflow_a: assert property (@(posedge clk_sys) disable iff (rst)
    (cur.count == FULL && !pop && !flush) |=> (cur.count == FULL))
    else $error("buffer count moved while full");

endmodule // usf_buf2

//--- logic/usf_core.sv
`timescale 1ns/1ps
// Function
// - Abort write stops operation and empties transmit and receive data storage.
// - Abort bit is a write-one event returning to idle, reads zero.
// - Port has exactly two interrupt flags: receive complete, transmit complete.
// - Interrupt request raised only when matching enable bit is one.
// - Two DMA trigger lines per port: receive and transmit.
// - DMA triggers pulse on the same events that set the flags.
// - Data buffer register serves as DMA source and destination.
// - Mode bit 7 and slave bit 5, read/write, reset zero.
// - Bit 6 enables the UART receiver, reset zero.
// - Bit 4 sets on wrong stop level, write zero clears.
// - Receive flags set when first stop bit checks valid; here any accepted rxDone sets them, also with rxStopBad.
// - Bad second stop bit sets framing fault one bit later.
// - Bit 3 sets on parity failure, write zero clears.
// - Bit 2 sets when received byte ready, write zero clears.
// - Bit 1 sets when last written byte fully sent, write zero clears; here every accepted txDone sets it, also with bytes still buffered.
// - Bit 0 reads one while busy, zero when idle, read-only.
module usf_core #(
  parameter int BUF_DEPTH = usf_pkg::BUF_DEPTH
) (
  // Clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       rst,
  // Wishbone classic slave
  input  wire logic                       wb_cyc_i,
  input  wire logic                       wb_stb_i,
  input  wire logic                       wb_we_i,
  input  wire logic [usf_pkg::ADR_W-1:0]  wb_adr_i,
  input  wire logic [3:0]                 wb_sel_i,
  input  wire logic [31:0]                wb_dat_i,
  output logic [31:0]                     wb_dat_o,
  output logic                            wb_ack_o,
  // Transmit bytes toward the shift engine
  output logic                            txValid,
  input  wire logic                       txReady,
  output logic [usf_pkg::DATA_W-1:0]      txData,
  // Events from the shift engine
  input  wire logic                       rxDone,
  input  wire logic [usf_pkg::DATA_W-1:0] rxData,
  input  wire logic                       rxParityBad,
  input  wire logic                       rxStopBad,
  input  wire logic                       rxStop2Bad,
  input  wire logic                       txDone,
  input  wire logic                       lineActive,
  // Configuration toward the shift engine
  output logic                            uartMode,
  output logic                            spiSlave,
  output logic                            rxEnable,
  output logic                            sckPhase,
  output logic                            twoStop,
  output logic                            abortPulse,
  // Interrupt requests and DMA triggers
  output logic                            rxIrq,
  output logic                            txIrq,
  output logic                            rxDmaTrig,
  output logic                            txDmaTrig
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    usf_pkg::usf_state_e         st;
    logic                        mode;
    logic                        rxEn;
    logic                        slave;
    logic                        frame;
    logic                        parity;
    logic                        rxByte;
    logic                        txByte;
    logic                        phase;
    logic                        twoStop;
    logic                        rxIe;
    logic                        txIe;
    logic                        rxFlag;
    logic                        txFlag;
    logic [usf_pkg::DATA_W-1:0]  rxBuf;
    logic                        abort;
    logic                        rxTrig;
    logic                        txTrig;
  } usf_core_s;

  usf_core_s cur;
  usf_core_s next_cur;

  usf_if regs();

  logic wrCsr;
  logic wrCtl;
  logic wrIrq;
  logic wrData;
  logic abortNow;
  logic rxAccept;
  logic txAccept;
  logic frameSet;
  logic bufInReady;
  logic bufOutValid;
  logic busyBit;
  logic wrModeBit;
  logic wrSlaveBit;
  logic wrRxEnBit;

  // ---------------------------------------------------------------
  // Bus slave and transmit buffer
  // ---------------------------------------------------------------
  usf_wb_slave u_wbs (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .wb_cyc_i (wb_cyc_i),
    .wb_stb_i (wb_stb_i),
    .wb_we_i  (wb_we_i),
    .wb_adr_i (wb_adr_i),
    .wb_sel_i (wb_sel_i),
    .wb_dat_i (wb_dat_i),
    .wb_dat_o (wb_dat_o),
    .wb_ack_o (wb_ack_o),
    .regs     (regs)
  );

  // Bytes written to the data buffer wait here for the engine
  usf_buf2 #(
    .W     (usf_pkg::DATA_W),
    .DEPTH (BUF_DEPTH)
  ) u_txbuf (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .flush    (abortNow),
    .inValid  (wrData),
    .inReady  (bufInReady),
    .inData   (regs.wdata),
    .outValid (bufOutValid),
    .outReady (txReady),
    .outData  (txData)
  );

  // ---------------------------------------------------------------
  // Access decode and event qualification
  // ---------------------------------------------------------------
  assign wrCsr    = regs.req & regs.we & (regs.idx == usf_pkg::IDX_CSR);
  assign wrCtl    = regs.req & regs.we & (regs.idx == usf_pkg::IDX_CTL);
  assign wrIrq    = regs.req & regs.we & (regs.idx == usf_pkg::IDX_IRQ);
  assign wrData   = regs.req & regs.we & (regs.idx == usf_pkg::IDX_DATA);
  assign abortNow = wrCtl & regs.wdata[usf_pkg::CTL_ABORT];
  // A full buffer holds the bus write off until the engine drains it
  assign regs.stall = regs.we & (regs.idx == usf_pkg::IDX_DATA) & ~bufInReady;
  // Receive events count in SPI mode, or in UART mode with receiver on
  assign rxAccept = rxDone & (~cur.mode | cur.rxEn) & ~abortNow & (cur.st != usf_pkg::USF_FLUSH);
  assign txAccept = txDone & ~abortNow & (cur.st != usf_pkg::USF_FLUSH);
  assign frameSet = (rxAccept & rxStopBad) |
                    (rxStop2Bad & cur.twoStop & cur.mode & cur.rxEn & ~abortNow);
  assign busyBit  = (cur.st == usf_pkg::USF_BUSY);
  assign wrModeBit  = regs.wdata[usf_pkg::CSR_MODE];
  assign wrSlaveBit = regs.wdata[usf_pkg::CSR_SLAVE];
  assign wrRxEnBit  = regs.wdata[usf_pkg::CSR_RXEN];

  // ---------------------------------------------------------------
  // Read multiplexer
  // ---------------------------------------------------------------
  always_comb
  begin
    case (regs.idx)
      usf_pkg::IDX_CSR:
        regs.rdata = {cur.mode, cur.rxEn, cur.slave, cur.frame,
                      cur.parity, cur.rxByte, cur.txByte, busyBit};
      usf_pkg::IDX_CTL:
        regs.rdata = {1'b0, cur.phase, 3'b000, cur.twoStop, 2'b00};
      usf_pkg::IDX_IRQ:
        regs.rdata = {2'b00, cur.txFlag, cur.rxFlag, 2'b00, cur.txIe, cur.rxIe};
      usf_pkg::IDX_DATA:
        regs.rdata = cur.rxBuf;
      default:
        regs.rdata = 8'h00;
    endcase
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    next_cur = cur;
    // Configuration writes
    if (wrCsr)
    begin
      next_cur.mode  = wrModeBit;
      next_cur.slave = wrSlaveBit;
      next_cur.rxEn  = wrRxEnBit;
    end
    if (wrCtl)
    begin
      next_cur.phase   = regs.wdata[usf_pkg::CTL_PHASE];
      next_cur.twoStop = regs.wdata[usf_pkg::CTL_TWOSTOP];
    end
    if (wrIrq)
    begin
      next_cur.rxIe = regs.wdata[usf_pkg::IRQ_RXIE];
      next_cur.txIe = regs.wdata[usf_pkg::IRQ_TXIE];
    end
    // Status flags, cleared by writing zero
    next_cur.frame  = usf_pkg::usf_flag(cur.frame, frameSet,
                                        wrCsr & ~regs.wdata[usf_pkg::CSR_FRAME]);
    next_cur.parity = usf_pkg::usf_flag(cur.parity, rxAccept & rxParityBad,
                                        wrCsr & ~regs.wdata[usf_pkg::CSR_PARITY]);
    next_cur.rxByte = usf_pkg::usf_flag(cur.rxByte, rxAccept,
                                        wrCsr & ~regs.wdata[usf_pkg::CSR_RXBYTE]);
    next_cur.txByte = usf_pkg::usf_flag(cur.txByte, txAccept,
                                        wrCsr & ~regs.wdata[usf_pkg::CSR_TXBYTE]);
    // Interrupt flags
    next_cur.rxFlag = usf_pkg::usf_flag(cur.rxFlag, rxAccept,
                                        wrIrq & ~regs.wdata[usf_pkg::IRQ_RXFLAG]);
    next_cur.txFlag = usf_pkg::usf_flag(cur.txFlag, txAccept,
                                        wrIrq & ~regs.wdata[usf_pkg::IRQ_TXFLAG]);
    // Received byte and DMA triggers
    if (rxAccept)
      next_cur.rxBuf = rxData;
    next_cur.rxTrig = rxAccept;
    next_cur.txTrig = txAccept;
    next_cur.abort  = abortNow;
    // Activity state; busy bit is never written by software
    case (cur.st)
      usf_pkg::USF_IDLE:
        if (lineActive | bufOutValid)
          next_cur.st = usf_pkg::USF_BUSY;
      usf_pkg::USF_BUSY:
        if (~lineActive & ~bufOutValid)
          next_cur.st = usf_pkg::USF_IDLE;
      usf_pkg::USF_FLUSH:
        next_cur.st = usf_pkg::USF_IDLE;
      default:
        next_cur.st = usf_pkg::USF_IDLE;
    endcase
    if (abortNow)
    begin
      next_cur.st    = usf_pkg::USF_FLUSH;
      next_cur.rxBuf = usf_pkg::DATA_RESET;
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      cur         <= '0;
      cur.st      <= usf_pkg::USF_IDLE;
      cur.rxBuf   <= usf_pkg::DATA_RESET;
    end
    else
      cur <= next_cur;
  end

  // Outputs
  assign txValid    = bufOutValid;
  assign uartMode   = cur.mode;
  assign spiSlave   = cur.slave;
  assign rxEnable   = cur.rxEn;
  assign sckPhase   = cur.phase;
  assign twoStop    = cur.twoStop;
  assign abortPulse = cur.abort;
  assign rxIrq      = cur.rxFlag & cur.rxIe;
  assign txIrq      = cur.txFlag & cur.txIe;
  assign rxDmaTrig  = cur.rxTrig;
  assign txDmaTrig  = cur.txTrig;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence flushStep_q;
    (cur.st == usf_pkg::USF_FLUSH) && !busyBit && !bufOutValid && abortPulse;
  endsequence

  sequence idleStep_q;
    (cur.st == usf_pkg::USF_IDLE) && !abortPulse;
  endsequence

  abort_to_idle_a: assert property (abortNow |=> flushStep_q ##1 idleStep_q)
    else $error("abort did not return port to idle");
  abort_reads_zero_a: assert property ((regs.idx == usf_pkg::IDX_CTL) |-> !regs.rdata[usf_pkg::CTL_ABORT])
    else $error("abort bit read as one");
  rx_complete_set_a: assert property (rxAccept |=> cur.rxFlag && cur.rxByte && rxDmaTrig)
    else $error("receive event lost");
  tx_complete_set_a: assert property (txAccept |=> cur.txFlag && cur.txByte && txDmaTrig ##1 !txDmaTrig)
    else $error("transmit event lost");
  irq_gate_a: assert property ((rxIrq |-> cur.rxIe) and (txIrq |-> cur.txIe))
    else $error("interrupt without enable");
  trig_pulse_a: assert property ($rose(rxDmaTrig) |-> $past(rxDone))
    else $error("receive trigger without event");
  mode_write_a: assert property (wrCsr |=> cur.mode == $past(wrModeBit) && cur.slave == $past(wrSlaveBit))
    else $error("mode or slave write not taken");
  rx_disabled_a: assert property ((rxDone && cur.mode && !cur.rxEn && !wrIrq && !wrCsr)
                                  |=> $stable(cur.rxFlag) && $stable(cur.rxByte))
    else $error("disabled receiver raised flags");
  frame_late_a: assert property ((rxStop2Bad && cur.twoStop && cur.mode && cur.rxEn && !abortNow)
                                 |=> cur.frame)
    else $error("late framing fault missed");
  parity_set_a: assert property ((rxAccept && rxParityBad) |=> cur.parity)
    else $error("parity fault missed");
  busy_idle_a: assert property ((cur.st == usf_pkg::USF_IDLE && !lineActive && !bufOutValid && !abortNow)
                                |=> !busyBit)
    else $error("busy set while idle");

endmodule // usf_core

//--- logic/usf_if.sv
`timescale 1ns/1ps
// Register access path between bus slave and port core
interface usf_if;
  logic                       req;
  logic                       we;
  logic [usf_pkg::IDX_W-1:0]  idx;
  logic [7:0]                 wdata;
  logic [7:0]                 rdata;
  logic                       stall;

  modport bus  (output req, we, idx, wdata, input rdata, stall);
  modport core (input req, we, idx, wdata, output rdata, stall);
endinterface

//--- logic/usf_pkg.sv
package usf_pkg;

  // ---------------------------------------------------------------
  // Bus geometry
  // ---------------------------------------------------------------
  localparam int ADR_W  = 12;
  localparam int IDX_W  = 8;
  localparam int DATA_W = 8;
  localparam int BUF_DEPTH = 2;

  // ---------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_CSR  = 8'h86;  // port_control_status
  localparam logic [IDX_W-1:0] IDX_CTL  = 8'h87;  // uart_control_reg
  localparam logic [IDX_W-1:0] IDX_IRQ  = 8'h88;  // irq enables and flags
  localparam logic [IDX_W-1:0] IDX_DATA = 8'h89;  // data_buffer_reg

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CSR_MODE   = 7;
  localparam int CSR_RXEN   = 6;
  localparam int CSR_SLAVE  = 5;
  localparam int CSR_FRAME  = 4;
  localparam int CSR_PARITY = 3;
  localparam int CSR_RXBYTE = 2;
  localparam int CSR_TXBYTE = 1;
  localparam int CSR_BUSY   = 0;
  localparam int CTL_ABORT   = 7;
  localparam int CTL_PHASE   = 6;
  localparam int CTL_TWOSTOP = 2;
  localparam int IRQ_RXIE   = 0;
  localparam int IRQ_TXIE   = 1;
  localparam int IRQ_RXFLAG = 4;
  localparam int IRQ_TXFLAG = 5;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] CSR_RESET  = 8'h00;
  localparam logic [7:0] CTL_RESET  = 8'h00;
  localparam logic [7:0] IRQ_RESET  = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;

  // Port activity states
  typedef enum logic [1:0] {USF_IDLE, USF_BUSY, USF_FLUSH} usf_state_e;

  // Sticky flag: a set in the clearing cycle wins
  function automatic logic usf_flag(input logic held, input logic set, input logic clr);
    usf_flag = set | (held & ~clr);
  endfunction

endpackage

//--- logic/usf_wb_slave.sv
`timescale 1ns/1ps
module usf_wb_slave (
  // Clock and reset
  input  wire logic                      clk_sys,
  input  wire logic                      rst,
  // Wishbone classic slave
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [usf_pkg::ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                wb_sel_i,
  input  wire logic [31:0]               wb_dat_i,
  output logic [31:0]                    wb_dat_o,
  output logic                           wb_ack_o,
  // Register path
  usf_if.bus                             regs
);
  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } usf_wb_s;

  usf_wb_s cur;
  usf_wb_s next_cur;
  logic    inRange;

  // Decode: addresses above the index field are unmapped (index zero)
  assign inRange    = (wb_adr_i[usf_pkg::ADR_W-1:usf_pkg::IDX_W+2] == '0);
  assign regs.idx   = inRange ? wb_adr_i[usf_pkg::IDX_W+1:2] : '0;
  assign regs.we    = wb_we_i & wb_sel_i[0];
  assign regs.wdata = wb_dat_i[7:0];
  assign regs.req   = wb_cyc_i & wb_stb_i & ~cur.ack & ~regs.stall;
  assign wb_ack_o   = cur.ack;
  assign wb_dat_o   = cur.dat;

  // One ack per request, read data captured with it
  always_comb
  begin
    next_cur     = cur;
    next_cur.ack = regs.req;
    if (regs.req)
      next_cur.dat = {24'h000000, regs.rdata};
  end

  // State register
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      cur <= '0;
    else
      cur <= next_cur;
  end

  ack_single_a: assert property (@(posedge clk_sys) disable iff (rst)
    cur.ack |=> !cur.ack)
    else $error("ack held two cycles");

endmodule // usf_wb_slave

//--- tb/test_usart_status_irq_dma_flush.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin numChecks++; if ((got) !== (ex)) begin badCount++; $display("Error %s expected %h seen %h", nm, ex, got); end end
module test_usart_status_irq_dma_flush;
  // ---------------------------------------------------------------
  // Stimulus, partner and checks
  // ---------------------------------------------------------------
  localparam logic [11:0] ADR_CSR = {2'b00, usf_pkg::IDX_CSR, 2'b00};
  localparam logic [11:0] ADR_CTL = {2'b00, usf_pkg::IDX_CTL, 2'b00};
  localparam logic [11:0] ADR_IRQ = {2'b00, usf_pkg::IDX_IRQ, 2'b00};
  localparam logic [11:0] ADR_DAT = {2'b00, usf_pkg::IDX_DATA, 2'b00};
  typedef struct packed {logic [11:0] a; logic [7:0] w; logic [7:0] e;} usf_row_s;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [31:0] wdat = 32'h00000000;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o, txValid, txReady, rxDone, rxParityBad, rxStopBad, rxStop2Bad;
  logic        txDone, lineActive, rxIrq, txIrq, rxDmaTrig, txDmaTrig, abortPulse, twoStop;
  logic        uartMode, spiSlave, rxEnable, sckPhase;
  logic [7:0]  txData, rxData;
  logic        acked = 1'b0;
  int          badCount = 0;
  int          numChecks = 0;
  int          cycles = 0;
  int          rxTrigs = 0;
  int          txTrigs = 0;
  int          aborts = 0;
  usf_row_s    rows [7] = '{'{ADR_CSR, 8'hff, 8'he0}, '{ADR_CSR, 8'h00, 8'h00}, '{ADR_CTL, 8'h44, 8'h44},
                            '{ADR_CTL, 8'h00, 8'h00}, '{ADR_IRQ, 8'h03, 8'h03}, '{ADR_IRQ, 8'h00, 8'h00},
                            '{12'h418, 8'hff, 8'h00}};

  usf_core u_dut (.clk_sys(clk_sys), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .txValid(txValid),
    .txReady(txReady), .txData(txData), .rxDone(rxDone), .rxData(rxData), .rxParityBad(rxParityBad),
    .rxStopBad(rxStopBad), .rxStop2Bad(rxStop2Bad), .txDone(txDone), .lineActive(lineActive), .uartMode(uartMode),
    .spiSlave(spiSlave), .rxEnable(rxEnable), .sckPhase(sckPhase), .twoStop(twoStop), .abortPulse(abortPulse),
    .rxIrq(rxIrq), .txIrq(txIrq), .rxDmaTrig(rxDmaTrig), .txDmaTrig(txDmaTrig));
  usf_engine_model u_eng (.clk_sys(clk_sys), .rst(rst), .txValid(txValid), .txReady(txReady), .txData(txData),
    .rxDone(rxDone), .rxData(rxData), .rxParityBad(rxParityBad), .rxStopBad(rxStopBad),
    .rxStop2Bad(rxStop2Bad), .txDone(txDone), .lineActive(lineActive));

  // 40 MHz system clock
  always #12.5 clk_sys = ~clk_sys;

  // Pulse counters and hang guard
  always @(posedge clk_sys)
  begin
    cycles++;
    rxTrigs += (rxDmaTrig === 1'b1);
    txTrigs += (txDmaTrig === 1'b1);
    aborts  += (abortPulse === 1'b1);
    if (cycles == 20000)
    begin
      badCount++;
      endSim();
    end
  end

  // Verdict and end of run
  task automatic endSim;
    if (badCount == 0 && numChecks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // One classic Wishbone cycle, held until ack is sampled
  task automatic bus(input logic [11:0] a, input logic w, input logic [7:0] d, output logic [7:0] q);
    acked = 1'b0;
    @(posedge clk_sys);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= {24'h000000, d};
    do
      @(posedge clk_sys);
    while (wb_ack_o !== 1'b1);
    q = wb_dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    acked = 1'b1;
  endtask

  // Register write and checked read
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(a, 1'b1, d, q);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    logic [7:0] q;
    bus(a, 1'b0, 8'h00, q);
    `CHK("register read", e, q)
  endtask

  // Main sequence
  initial
  begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    rd(ADR_CSR, 8'h00);
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, rows[i].e);
    end
    // Received byte with errors, receive interrupt masked
    wr(ADR_CSR, 8'hc0);
    wr(ADR_IRQ, 8'h02);
    u_eng.rxByte(8'ha5, 1'b1, 1'b1);
    rd(ADR_CSR, 8'hdc);
    `CHK("rxIrq", 1'b0, rxIrq)
    `CHK("rx triggers", 1, rxTrigs)
    rd(ADR_DAT, 8'ha5);
    wr(ADR_IRQ, 8'h13);
    `CHK("rxIrq", 1'b1, rxIrq)
    wr(ADR_IRQ, 8'h03);
    rd(ADR_IRQ, 8'h03);
    wr(ADR_CSR, 8'hc0);
    rd(ADR_CSR, 8'hc0);
    // Two stop bits: framing fault lands one bit later
    wr(ADR_CTL, 8'h04);
    `CHK("twoStop", 1'b1, twoStop)
    u_eng.rxByte(8'h3c, 1'b0, 1'b0);
    rd(ADR_CSR, 8'hc4);
    u_eng.stop2Bad();
    rd(ADR_CSR, 8'hd4);
    // Receiver off in UART mode drops the byte
    wr(ADR_CSR, 8'h80);
    u_eng.rxByte(8'h11, 1'b0, 1'b0);
    rd(ADR_CSR, 8'h80);
    `CHK("rx triggers", 2, rxTrigs)
    // Stalled engine: buffer fills, third write waits
    wr(ADR_CTL, 8'h00);
    u_eng.stall <= 1'b1;
    wr(ADR_DAT, 8'h01);
    wr(ADR_DAT, 8'h02);
    `CHK("txData", 8'h01, txData)
    fork
      wr(ADR_DAT, 8'h03);
      begin
        repeat (20) @(posedge clk_sys);
        `CHK("full write ack", 1'b0, acked)
        u_eng.stall <= 1'b0;
      end
    join
    repeat (3) @(posedge clk_sys);
    rd(ADR_CSR, 8'h81);
    for (int n = 0; n < 1000 && (u_eng.sent.size() < 3 || lineActive !== 1'b0); n++)
      @(posedge clk_sys);
    repeat (3) @(posedge clk_sys);
    rd(ADR_CSR, 8'h82);
    `CHK("tx triggers", 3, txTrigs)
    for (int i = 0; i < 3; i++)
      `CHK("sent byte", 8'(i + 1), u_eng.sent[i])
    rd(ADR_IRQ, 8'h33);
    `CHK("txIrq", 1'b1, txIrq)
    // Abort with bytes waiting and a received byte held
    wr(ADR_CSR, 8'hc0);
    u_eng.stall <= 1'b1;
    wr(ADR_DAT, 8'h55);
    wr(ADR_DAT, 8'h66);
    u_eng.rxByte(8'h77, 1'b0, 1'b0);
    wr(ADR_CTL, 8'h80);
    `CHK("txValid", 1'b0, txValid)
    repeat (8) @(posedge clk_sys);
    `CHK("abort pulses", 1, aborts)
    rd(ADR_CTL, 8'h00);
    rd(ADR_CSR, 8'hc4);
    rd(ADR_DAT, 8'h00);
    u_eng.stall <= 1'b0;
    repeat (20) @(posedge clk_sys);
    `CHK("bytes sent", 3, u_eng.sent.size())
    // Mid-run reset: configuration pins, flags and enables return to zero
    wr(ADR_CSR, 8'h20);
    wr(ADR_CTL, 8'h40);
    `CHK("config pins", 4'b0011, {uartMode, rxEnable, spiSlave, sckPhase})
    `CHK("rxIrq", 1'b1, rxIrq)
    rst <= 1'b1;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    rd(ADR_CSR, 8'h00);
    rd(ADR_IRQ, 8'h00);
    `CHK("config pins", 4'b0000, {uartMode, rxEnable, spiSlave, sckPhase})
    `CHK("rxIrq", 1'b0, rxIrq)
    endSim();
  end
endmodule // test_usart_status_irq_dma_flush

//--- tb/usf_engine_model.sv
`timescale 1ns/1ps
module usf_engine_model #(
  parameter int BIT_CYC = 8
) (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // Byte stream from the core
  input  wire logic       txValid,
  output logic            txReady,
  input  wire logic [7:0] txData,
  // Events toward the core
  output logic            rxDone,
  output logic [7:0]      rxData,
  output logic            rxParityBad,
  output logic            rxStopBad,
  output logic            rxStop2Bad,
  output logic            txDone,
  output logic            lineActive
);
  logic       stall = 1'b0;
  int         shiftCnt;
  logic [7:0] sent[$];

  // Quiet event lines until a byte comes in
  initial
  begin
    rxDone      = 1'b0;
    rxData      = 8'h00;
    rxParityBad = 1'b0;
    rxStopBad   = 1'b0;
    rxStop2Bad  = 1'b0;
  end

  // Takes one byte, shifts it for ten bit times, then reports it sent
  always @(posedge clk_sys)
  begin
    txDone <= 1'b0;
    if (rst)
      shiftCnt <= 0;
    else if (txValid && txReady)
    begin
      sent.push_back(txData);
      shiftCnt <= 10 * BIT_CYC;
    end
    else if (shiftCnt > 0)
    begin
      shiftCnt <= shiftCnt - 1;
      txDone   <= (shiftCnt == 1);
    end
  end

  // A stalled or shifting engine takes nothing new
  assign txReady    = !stall && shiftCnt == 0;
  assign lineActive = shiftCnt != 0;

  // One received byte; data is scrambled outside its pulse
  task automatic rxByte(input logic [7:0] d, input logic par, input logic stop);
    @(posedge clk_sys);
    rxDone      <= 1'b1;
    rxData      <= d;
    rxParityBad <= par;
    rxStopBad   <= stop;
    @(posedge clk_sys);
    rxDone      <= 1'b0;
    rxData      <= ~d;
    rxParityBad <= 1'b0;
    rxStopBad   <= 1'b0;
  endtask

  // Bad second stop bit, one bit time after the byte
  task automatic stop2Bad;
    repeat (BIT_CYC - 1) @(posedge clk_sys);
    rxStop2Bad <= 1'b1;
    @(posedge clk_sys);
    rxStop2Bad <= 1'b0;
  endtask
endmodule // usf_engine_model
